// ### src/sfrpe_core.sv
// sfrpe_core: serial flash command engine, read, program and erase
// assumes a host on sck_i/cs_n_i/si_i and cs_n_i high >= 4 clk_i periods
//
// Overview of operation
// - each opcode, address or data byte takes exactly eight serial clocks
// - opcode 03h plus three address bytes streams data until select rises
// - read pointer increments per output byte and wraps to zero
// - opcode 0bh adds one ignored dummy byte before data output
// - address bits above bit 15 are ignored
// - opcode 02h, address, data byte; program starts on select rising
// - byte program into a protected region is ignored
// - opcode afh, address, data starts sequential programming
// - in sequential mode afh plus data programs the next address
// - sequential mode stops at top free address and clears the latch
// - sequential start into a protected region is ignored
// - opcode 20h erases the 4 KByte sector chosen by bits 15..12
// - opcode 52h or d8h erases the 32 KByte block chosen by bit 15
// - opcode 60h or c7h erases the whole array
// - chip erase is ignored while any part is protected
// - sector or block erase into a protected region is ignored
// - program and erase start only on the following select rise
// - status read repeats the status byte until select rises
// - status write acts only right after the status arm command
// - id read: address bit 0 picks maker or part, then alternates
// - inputs sampled on rising serial clock, msb first, framed by select
// - select rising inside a byte aborts the command
// - two protect level bits pick none, quarter, half or all; reset 11
// - latch set command sets the write enable latch
`timescale 1ns/1ps
`default_nettype none
module sfrpe_core #(
  parameter sfrpe_pkg::sfrpe_tmr_t SECTOR_CYC = sfrpe_pkg::sfrpe_tmr_t'(sfrpe_pkg::SECTOR_CYC),
  parameter sfrpe_pkg::sfrpe_tmr_t BLOCK_CYC  = sfrpe_pkg::sfrpe_tmr_t'(sfrpe_pkg::BLOCK_CYC),
  parameter sfrpe_pkg::sfrpe_tmr_t CHIP_CYC   = sfrpe_pkg::sfrpe_tmr_t'(sfrpe_pkg::CHIP_CYC)
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  output logic            so_o,
  output logic            so_oe_n_o,
  output logic            busy_o,
  output logic            write_enable_latch_o,
  output logic            sequential_program_mode_o,
  output logic [1:0]      protect_level_o
);
  localparam logic [2:0]            LAST_BIT = 3'(sfrpe_pkg::SLOT_BITS - 1);
  localparam sfrpe_pkg::sfrpe_tmr_t PROG_CYC = sfrpe_pkg::sfrpe_tmr_t'(sfrpe_pkg::BYTE_PROG_CYC);

  function automatic logic is_protected(input logic [1:0] lvl,
                                        input sfrpe_pkg::sfrpe_addr_t a);
    case (lvl)
      2'h0:    is_protected = 1'b0;
      2'h1:    is_protected = (a >= sfrpe_pkg::QUARTER_BASE);
      2'h2:    is_protected = (a >= sfrpe_pkg::HALF_BASE);
      default: is_protected = 1'b1;
    endcase
  endfunction

  function automatic sfrpe_pkg::sfrpe_addr_t next_addr(input sfrpe_pkg::sfrpe_addr_t a);
    next_addr = a + 16'h0001;
  endfunction

  function automatic logic cmd_complete(input logic [7:0] op,
                                        input logic [2:0] idx,
                                        input logic       seq);
    case (op)
      sfrpe_pkg::OP_LATCH_SET,
      sfrpe_pkg::OP_LATCH_CLEAR,
      sfrpe_pkg::OP_STATUS_ARM,
      sfrpe_pkg::OP_CHIP_ERASE1,
      sfrpe_pkg::OP_CHIP_ERASE2:  cmd_complete = (idx == 3'h0);
      sfrpe_pkg::OP_STATUS_WRITE: cmd_complete = (idx == 3'h1);
      sfrpe_pkg::OP_SECTOR_ERASE,
      sfrpe_pkg::OP_BLOCK_ERASE1,
      sfrpe_pkg::OP_BLOCK_ERASE2: cmd_complete = (idx == 3'h3);
      sfrpe_pkg::OP_BYTE_PROG:    cmd_complete = (idx == 3'h4);
      sfrpe_pkg::OP_SEQ_PROG:     cmd_complete = seq ? (idx == 3'h1) : (idx == 3'h4);
      default:                    cmd_complete = 1'b0;
    endcase
  endfunction

  sfrpe_mem_if mem_bus ();

  sfrpe_mem u_mem (
    .port (mem_bus)
  );

  // link side, serial clock domain
  logic                   frame_rst;
  logic [2:0]             bit_cnt_r,  bit_cnt_nxt;
  logic [2:0]             byte_cnt_r, byte_cnt_nxt;
  logic [6:0]             shift_r,    shift_nxt;
  logic                   load_r,     load_nxt;
  logic                   sel_mem_r,  sel_mem_nxt;
  logic [7:0]             aux_r,      aux_nxt;
  logic                   id_sel_r,   id_sel_nxt;
  logic [7:0]             op_r,       op_nxt;
  sfrpe_pkg::sfrpe_addr_t addr_r,     addr_nxt;
  logic [7:0]             data_r,     data_nxt;
  logic                   req_r,      req_nxt;
  sfrpe_pkg::sfrpe_addr_t rd_ptr_r,   rd_ptr_nxt;
  sfrpe_pkg::sfrpe_addr_t rd_addr;
  logic [7:0]             st_s1_r,    st_s2_r;
  logic [7:0]             out_r,      out_nxt;
  logic                   oe_r,       oe_nxt;
  logic [7:0]             in_byte;
  logic [7:0]             op_now;
  logic                   byte_done;
  logic                   id_pick;

  // system side
  logic                   cs_s1_r, cs_s2_r, cs_s3_r;
  logic                   cs_rise;
  sfrpe_pkg::sfrpe_state_e state_r, state_nxt;
  sfrpe_pkg::sfrpe_tmr_t  tmr_r,      tmr_nxt;
  sfrpe_pkg::sfrpe_addr_t wptr_r,     wptr_nxt;
  sfrpe_pkg::sfrpe_addr_t wend_r,     wend_nxt;
  logic [7:0]             wdat_r,     wdat_nxt;
  logic                   walk_done_r, walk_done_nxt;
  logic                   wel_r,      wel_nxt;
  logic                   seq_r,      seq_nxt;
  sfrpe_pkg::sfrpe_addr_t seq_addr_r, seq_addr_nxt;
  logic [1:0]             bp_r,       bp_nxt;
  logic                   arm_r,      arm_nxt;
  logic [7:0]             status_c;
  logic                   idle;
  logic                   go;
  sfrpe_pkg::sfrpe_state_e go_state;
  sfrpe_pkg::sfrpe_addr_t go_base, go_end, tgt;
  sfrpe_pkg::sfrpe_tmr_t  go_tmr;

  // frame logic is cleared while select is high, so a partial byte dies
  assign frame_rst = cs_n_i | ~rst_n_i;

  always_comb
  begin
    in_byte      = {shift_r, si_i};
    byte_done    = (bit_cnt_r == LAST_BIT);
    op_now       = (byte_cnt_r == 3'h0) ? in_byte : op_r;
    bit_cnt_nxt  = bit_cnt_r + 3'h1;
    shift_nxt    = in_byte[6:0];
    byte_cnt_nxt = byte_cnt_r;
    load_nxt     = 1'b0;
    sel_mem_nxt  = sel_mem_r;
    aux_nxt      = aux_r;
    id_sel_nxt   = id_sel_r;
    id_pick      = id_sel_r;
    op_nxt       = op_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    rd_ptr_nxt   = rd_ptr_r;
    rd_addr      = rd_ptr_r;
    req_nxt      = 1'b0;
    if (byte_done)
    begin
      if (byte_cnt_r != 3'h7)
      begin
        byte_cnt_nxt = byte_cnt_r + 3'h1;
      end
      data_nxt = in_byte;
      req_nxt  = cmd_complete(op_now, byte_cnt_r, st_s2_r[sfrpe_pkg::ST_SEQ]);
      if (byte_cnt_r == 3'h0)
      begin
        op_nxt = in_byte;
      end
      if (byte_cnt_r >= 3'h1 && byte_cnt_r <= 3'h3)
      begin
        addr_nxt = {addr_r[7:0], in_byte};
      end
      case (op_now)
        sfrpe_pkg::OP_READ,
        sfrpe_pkg::OP_FAST_READ:
        begin
          if (byte_cnt_r == 3'h3)
          begin
            rd_ptr_nxt = {addr_r[7:0], in_byte};
            if (op_now == sfrpe_pkg::OP_READ)
            begin
              rd_addr     = {addr_r[7:0], in_byte};
              rd_ptr_nxt  = next_addr(rd_addr);
              load_nxt    = 1'b1;
              sel_mem_nxt = 1'b1;
            end
          end
          else if (byte_cnt_r > 3'h3)
          begin
            // fast read lands here first after its dummy byte
            rd_ptr_nxt  = next_addr(rd_ptr_r);
            load_nxt    = 1'b1;
            sel_mem_nxt = 1'b1;
          end
        end
        sfrpe_pkg::OP_STATUS_READ:
        begin
          load_nxt    = 1'b1;
          sel_mem_nxt = 1'b0;
          aux_nxt     = st_s2_r;
        end
        sfrpe_pkg::OP_ID_READ1,
        sfrpe_pkg::OP_ID_READ2:
        begin
          if (byte_cnt_r >= 3'h3)
          begin
            id_pick     = (byte_cnt_r == 3'h3) ? in_byte[0] : ~id_sel_r;
            id_sel_nxt  = id_pick;
            load_nxt    = 1'b1;
            sel_mem_nxt = 1'b0;
            aux_nxt     = id_pick ? sfrpe_pkg::PART_ID : sfrpe_pkg::MAKER_ID;
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge sck_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 3'h0;
      shift_r    <= 7'h00;
      load_r     <= 1'b0;
      sel_mem_r  <= 1'b0;
      aux_r      <= 8'h00;
      id_sel_r   <= 1'b0;
    end
    else
    begin
      bit_cnt_r  <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      shift_r    <= shift_nxt;
      load_r     <= load_nxt;
      sel_mem_r  <= sel_mem_nxt;
      aux_r      <= aux_nxt;
      id_sel_r   <= id_sel_nxt;
    end
  end

  // command capture survives select rising so the system side can act on it
  always_ff @(posedge sck_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_r     <= 8'h00;
      addr_r   <= 16'h0000;
      data_r   <= 8'h00;
      req_r    <= 1'b0;
      rd_ptr_r <= 16'h0000;
      st_s1_r  <= 8'h00;
      st_s2_r  <= 8'h00;
    end
    else
    begin
      op_r     <= op_nxt;
      addr_r   <= addr_nxt;
      data_r   <= data_nxt;
      req_r    <= req_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      st_s1_r  <= status_c;
      st_s2_r  <= st_s1_r;
    end
  end

  always_comb
  begin
    out_nxt = load_r ? (sel_mem_r ? mem_bus.rdata : aux_r) : {out_r[6:0], 1'b0};
    oe_nxt  = oe_r | load_r;
  end

  always_ff @(negedge sck_i or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      out_r <= 8'h00;
      oe_r  <= 1'b0;
    end
    else
    begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
    end
  end

  assign so_o      = out_r[7];
  assign so_oe_n_o = ~oe_r;

  assign mem_bus.rclk  = sck_i;
  assign mem_bus.raddr = rd_addr;
  assign mem_bus.wclk  = clk_i;
  assign mem_bus.we    = (state_r != sfrpe_pkg::SFRPE_IDLE) && !walk_done_r;
  assign mem_bus.waddr = wptr_r;
  assign mem_bus.wdata = (state_r == sfrpe_pkg::SFRPE_PROG) ? wdat_r : sfrpe_pkg::ERASED_BYTE;

  // select is the only level synchronised onto the system clock; command fields are stable by then
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end
    else
    begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  assign cs_rise = cs_s2_r & ~cs_s3_r;
  assign idle    = (state_r == sfrpe_pkg::SFRPE_IDLE);

  always_comb
  begin
    status_c                       = 8'h00;
    status_c[sfrpe_pkg::ST_BUSY]   = ~idle;
    status_c[sfrpe_pkg::ST_WEL]    = wel_r;
    status_c[sfrpe_pkg::ST_PL_LO]  = bp_r[0];
    status_c[sfrpe_pkg::ST_PL_HI]  = bp_r[1];
    status_c[sfrpe_pkg::ST_SEQ]    = seq_r;
  end

  always_comb
  begin
    state_nxt     = state_r;
    tmr_nxt       = tmr_r;
    wptr_nxt      = wptr_r;
    wend_nxt      = wend_r;
    wdat_nxt      = wdat_r;
    walk_done_nxt = walk_done_r;
    wel_nxt       = wel_r;
    seq_nxt       = seq_r;
    seq_addr_nxt  = seq_addr_r;
    bp_nxt        = bp_r;
    arm_nxt       = arm_r;
    tgt           = seq_r ? next_addr(seq_addr_r) : addr_r;
    go            = 1'b0;
    go_state      = sfrpe_pkg::SFRPE_PROG;
    go_base       = addr_r;
    go_end        = addr_r;
    go_tmr        = PROG_CYC;
    case (state_r)
      sfrpe_pkg::SFRPE_PROG,
      sfrpe_pkg::SFRPE_ERASE:
      begin
        if (!walk_done_r)
        begin
          if (wptr_r == wend_r)
          begin
            walk_done_nxt = 1'b1;
          end
          else
          begin
            wptr_nxt = next_addr(wptr_r);
          end
        end
        if (tmr_r != 20'h00000)
        begin
          tmr_nxt = tmr_r - 20'h00001;
        end
        else if (walk_done_r)
        begin
          state_nxt = sfrpe_pkg::SFRPE_IDLE;
          if (state_r == sfrpe_pkg::SFRPE_PROG && seq_r
              && seq_addr_r == (is_protected(bp_r, sfrpe_pkg::HALF_BASE)
                                ? (is_protected(bp_r, sfrpe_pkg::QUARTER_BASE - 16'h0001)
                                   ? sfrpe_pkg::HALF_BASE - 16'h0001
                                   : sfrpe_pkg::HALF_BASE - 16'h0001)
                                : (is_protected(bp_r, sfrpe_pkg::QUARTER_BASE)
                                   ? sfrpe_pkg::QUARTER_BASE - 16'h0001
                                   : sfrpe_pkg::TOP_ADDR)))
          begin
            seq_nxt = 1'b0;
            wel_nxt = 1'b0;
          end
        end
      end
      sfrpe_pkg::SFRPE_IDLE:
      begin
      end
      default:
      begin
        state_nxt = sfrpe_pkg::SFRPE_IDLE;
      end
    endcase
    if (cs_rise)
    begin
      arm_nxt = req_r && (op_r == sfrpe_pkg::OP_STATUS_ARM);
      if (req_r)
      begin
        case (op_r)
          sfrpe_pkg::OP_LATCH_SET:
          begin
            wel_nxt = 1'b1;
          end
          sfrpe_pkg::OP_LATCH_CLEAR:
          begin
            wel_nxt = 1'b0;
            seq_nxt = 1'b0;
          end
          sfrpe_pkg::OP_STATUS_WRITE:
          begin
            if (arm_r && idle)
            begin
              bp_nxt = data_r[sfrpe_pkg::ST_PL_HI:sfrpe_pkg::ST_PL_LO];
            end
          end
          sfrpe_pkg::OP_BYTE_PROG:
          begin
            go = wel_r && idle && !is_protected(bp_r, addr_r);
          end
          sfrpe_pkg::OP_SEQ_PROG:
          begin
            go       = wel_r && idle && !is_protected(bp_r, tgt);
            go_base  = tgt;
            go_end   = tgt;
          end
          sfrpe_pkg::OP_SECTOR_ERASE:
          begin
            go       = wel_r && idle && !is_protected(bp_r, addr_r | sfrpe_pkg::SECTOR_MASK);
            go_state = sfrpe_pkg::SFRPE_ERASE;
            go_base  = addr_r & ~sfrpe_pkg::SECTOR_MASK;
            go_end   = addr_r | sfrpe_pkg::SECTOR_MASK;
            go_tmr   = SECTOR_CYC;
          end
          sfrpe_pkg::OP_BLOCK_ERASE1,
          sfrpe_pkg::OP_BLOCK_ERASE2:
          begin
            go       = wel_r && idle && !is_protected(bp_r, addr_r | sfrpe_pkg::BLOCK_MASK);
            go_state = sfrpe_pkg::SFRPE_ERASE;
            go_base  = addr_r & ~sfrpe_pkg::BLOCK_MASK;
            go_end   = addr_r | sfrpe_pkg::BLOCK_MASK;
            go_tmr   = BLOCK_CYC;
          end
          sfrpe_pkg::OP_CHIP_ERASE1,
          sfrpe_pkg::OP_CHIP_ERASE2:
          begin
            go       = wel_r && idle && (bp_r == 2'h0);
            go_state = sfrpe_pkg::SFRPE_ERASE;
            go_base  = 16'h0000;
            go_end   = sfrpe_pkg::TOP_ADDR;
            go_tmr   = CHIP_CYC;
          end
          default:
          begin
          end
        endcase
      end
    end
    if (go)
    begin
      state_nxt     = go_state;
      tmr_nxt       = go_tmr;
      wptr_nxt      = go_base;
      wend_nxt      = go_end;
      wdat_nxt      = data_r;
      walk_done_nxt = 1'b0;
      if (op_r == sfrpe_pkg::OP_SEQ_PROG)
      begin
        seq_nxt      = 1'b1;
        seq_addr_nxt = go_base;
      end
      else
      begin
        wel_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r     <= sfrpe_pkg::SFRPE_IDLE;
      tmr_r       <= 20'h00000;
      wptr_r      <= 16'h0000;
      wend_r      <= 16'h0000;
      wdat_r      <= 8'hff;
      walk_done_r <= 1'b1;
      wel_r       <= 1'b0;
      seq_r       <= 1'b0;
      seq_addr_r  <= 16'h0000;
      bp_r        <= sfrpe_pkg::PROTECT_RST;
      arm_r       <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      tmr_r       <= tmr_nxt;
      wptr_r      <= wptr_nxt;
      wend_r      <= wend_nxt;
      wdat_r      <= wdat_nxt;
      walk_done_r <= walk_done_nxt;
      wel_r       <= wel_nxt;
      seq_r       <= seq_nxt;
      seq_addr_r  <= seq_addr_nxt;
      bp_r        <= bp_nxt;
      arm_r       <= arm_nxt;
    end
  end

  assign busy_o                    = ~idle;
  assign write_enable_latch_o      = wel_r;
  assign sequential_program_mode_o = seq_r;
  assign protect_level_o           = bp_r;
endmodule
`default_nettype wire

// ### src/sfrpe_mem.sv
// sfrpe_mem: 64 KByte array, write port and registered read port
// assumes the two clocks never touch one address at once
`timescale 1ns/1ps
`default_nettype none
module sfrpe_mem (
  sfrpe_mem_if.mem port
);
  logic [7:0] store [0:65535];
  logic [7:0] rdata_r;

  always_ff @(posedge port.wclk)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
  end

  // no reset: contents are undefined until erased
  always_ff @(posedge port.rclk)
  begin
    rdata_r <= store[port.raddr];
  end

  assign port.rdata = rdata_r;
endmodule
`default_nettype wire

// ### src/sfrpe_mem_if.sv
// sfrpe_mem_if: array port bundle between the engine and its memory
// assumes writes on the system clock and reads on the serial clock
`timescale 1ns/1ps
`default_nettype none
interface sfrpe_mem_if;
  logic        wclk;
  logic        we;
  logic [15:0] waddr;
  logic [7:0]  wdata;
  logic        rclk;
  logic [15:0] raddr;
  logic [7:0]  rdata;
  modport ctrl (output wclk, we, waddr, wdata, rclk, raddr, input rdata);
  modport mem  (input wclk, we, waddr, wdata, rclk, raddr, output rdata);
endinterface
`default_nettype wire

// ### src/sfrpe_pkg.sv
// sfrpe_pkg: constants and types of the serial flash command engine
// assumes a 10 MHz system clock and a 64 KByte array (16 address bits)
package sfrpe_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          SLOT_BITS       = 8;
  localparam int          TMR_W           = 20;
  typedef logic [ADDR_W-1:0] sfrpe_addr_t;
  typedef logic [TMR_W-1:0]  sfrpe_tmr_t;

  localparam logic [7:0]  OP_READ         = 8'h03;
  localparam logic [7:0]  OP_FAST_READ    = 8'h0b;
  localparam logic [7:0]  OP_BYTE_PROG    = 8'h02;
  localparam logic [7:0]  OP_SEQ_PROG     = 8'haf;
  localparam logic [7:0]  OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0]  OP_BLOCK_ERASE1 = 8'h52;
  localparam logic [7:0]  OP_BLOCK_ERASE2 = 8'hd8;
  localparam logic [7:0]  OP_CHIP_ERASE1  = 8'h60;
  localparam logic [7:0]  OP_CHIP_ERASE2  = 8'hc7;
  localparam logic [7:0]  OP_STATUS_READ  = 8'h05;
  localparam logic [7:0]  OP_STATUS_ARM   = 8'h50;
  localparam logic [7:0]  OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0]  OP_LATCH_SET    = 8'h06;
  localparam logic [7:0]  OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0]  OP_ID_READ1     = 8'h90;
  localparam logic [7:0]  OP_ID_READ2     = 8'hab;

  // identification values are arbitrary
  localparam logic [7:0]  MAKER_ID        = 8'h5a;
  localparam logic [7:0]  PART_ID         = 8'h3c;

  localparam logic [1:0]  PROTECT_RST     = 2'h3;
  localparam sfrpe_addr_t QUARTER_BASE    = 16'hc000;
  localparam sfrpe_addr_t HALF_BASE       = 16'h8000;
  localparam sfrpe_addr_t SECTOR_MASK     = 16'h0fff;
  localparam sfrpe_addr_t BLOCK_MASK      = 16'h7fff;
  localparam sfrpe_addr_t TOP_ADDR        = 16'hffff;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;

  localparam int          ST_BUSY         = 0;
  localparam int          ST_WEL          = 1;
  localparam int          ST_PL_LO        = 2;
  localparam int          ST_PL_HI        = 3;
  localparam int          ST_SEQ          = 6;

  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          BYTE_PROG_NS    = 14000;
  localparam int          SECTOR_ERASE_US = 18000;
  localparam int          BLOCK_ERASE_US  = 18000;
  localparam int          CHIP_ERASE_US   = 70000;
  localparam int          BYTE_PROG_CYC   = (BYTE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SECTOR_CYC      = (SECTOR_ERASE_US * 1000) / CLK_PERIOD_NS;
  localparam int          BLOCK_CYC       = (BLOCK_ERASE_US * 1000) / CLK_PERIOD_NS;
  localparam int          CHIP_CYC        = (CHIP_ERASE_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SFRPE_IDLE  = 2'b00,
    SFRPE_PROG  = 2'b01,
    SFRPE_ERASE = 2'b10
  } sfrpe_state_e;
endpackage

// ### testbench/sfrpe_core_bench.sv
// sfrpe_core_bench: self-checking bench of the serial flash engine
// assumes sfrpe_host on the link; erase timers shortened to 100
`timescale 1ns/1ps
`default_nettype none
module sfrpe_core_bench;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       sck, cs_n, si, so, oe_n, busy, write_enable_latch, seq, tgl;
  logic [1:0] pl;
  logic [7:0] rx, d, hi;
  logic [7:0] exp_q[$];
  int         err_total = 0;
  int         num_checks = 0;
  always #50 clk_i = ~clk_i;
  sfrpe_core #(.SECTOR_CYC(20'd100), .BLOCK_CYC(20'd100), .CHIP_CYC(20'd100)) u_sfrpe_core (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
    .so_oe_n_o(oe_n), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
    .sequential_program_mode_o(seq), .protect_level_o(pl));
  sfrpe_host u_sfrpe_host (.so_i(so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .rx_o(rx),
    .rx_tgl_o(tgl));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(tgl)
    if (rst_n_i === 1'b1)
      check("read byte", rx, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  task automatic hdr(input logic [7:0] op, input logic [23:0] a, input bit addr);
    u_sfrpe_host.open_frame();
    u_sfrpe_host.put(op);
    if (addr)
    begin
      u_sfrpe_host.put(a[23:16]);
      u_sfrpe_host.put(a[15:8]);
      u_sfrpe_host.put(a[7:0]);
    end
  endtask
  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    u_sfrpe_host.get();
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (busy !== 1'b0)
    begin
      err_total++;
      $display("[FAIL] busy wait expected 0 seen 1");
      tally_and_finish();
    end
  endtask
  initial
  begin
    void'($urandom(32'h0a77));
    d = 8'($urandom());
    hi = 8'($urandom());
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("protect level", {6'h00, pl}, 8'h03);
    check("oe_n", {7'h00, oe_n}, 8'h01);
    hdr(sfrpe_pkg::OP_STATUS_READ, 24'h0, 1'b0);
    rd(8'h0c);
    rd(8'h0c);
    u_sfrpe_host.close_frame();
    hdr(sfrpe_pkg::OP_STATUS_WRITE, 24'h0, 1'b0);
    u_sfrpe_host.put(8'h00);
    u_sfrpe_host.close_frame();
    check("unarmed level", {6'h00, pl}, 8'h03);
    hdr(sfrpe_pkg::OP_STATUS_ARM, 24'h0, 1'b0);
    u_sfrpe_host.close_frame();
    hdr(sfrpe_pkg::OP_STATUS_WRITE, 24'h0, 1'b0);
    u_sfrpe_host.put(8'h00);
    u_sfrpe_host.close_frame();
    check("armed level", {6'h00, pl}, 8'h00);
    hdr(sfrpe_pkg::OP_LATCH_SET, 24'h0, 1'b0);
    u_sfrpe_host.close_frame();
    check("latch", {7'h00, write_enable_latch}, 8'h01);
    hdr(sfrpe_pkg::OP_CHIP_ERASE2, 24'h0, 1'b0);
    u_sfrpe_host.close_frame();
    check("erase busy", {7'h00, busy}, 8'h01);
    wait_idle(70000);
    hdr(sfrpe_pkg::OP_LATCH_SET, 24'h0, 1'b0);
    u_sfrpe_host.close_frame();
    hdr(sfrpe_pkg::OP_BYTE_PROG, {hi, 16'hffff}, 1'b1);
    u_sfrpe_host.put(d, 4);
    u_sfrpe_host.close_frame();
    check("abort busy", {7'h00, busy}, 8'h00);
    check("abort latch", {7'h00, write_enable_latch}, 8'h01);
    hdr(sfrpe_pkg::OP_BYTE_PROG, {hi, 16'hffff}, 1'b1);
    u_sfrpe_host.put(d);
    u_sfrpe_host.close_frame();
    check("program busy", {7'h00, busy}, 8'h01);
    wait_idle(300);
    hdr(sfrpe_pkg::OP_READ, {~hi, 16'hfffe}, 1'b1);
    rd(8'hff);
    rd(d);
    rd(8'hff);
    u_sfrpe_host.close_frame();
    hdr(sfrpe_pkg::OP_FAST_READ, {hi, 16'hffff}, 1'b1);
    u_sfrpe_host.put(~d);
    rd(d);
    rd(8'hff);
    u_sfrpe_host.close_frame();
    hdr(sfrpe_pkg::OP_LATCH_SET, 24'h0, 1'b0);
    u_sfrpe_host.close_frame();
    hdr(sfrpe_pkg::OP_SEQ_PROG, 24'h1000, 1'b1);
    u_sfrpe_host.put(d);
    u_sfrpe_host.close_frame();
    wait_idle(300);
    check("seq mode", {7'h00, seq}, 8'h01);
    hdr(sfrpe_pkg::OP_SEQ_PROG, 24'h0, 1'b0);
    u_sfrpe_host.put(~d);
    u_sfrpe_host.close_frame();
    wait_idle(300);
    hdr(sfrpe_pkg::OP_READ, 24'h1000, 1'b1);
    rd(d);
    rd(~d);
    u_sfrpe_host.close_frame();
    hdr(sfrpe_pkg::OP_ID_READ1, 24'h000001, 1'b1);
    rd(sfrpe_pkg::PART_ID);
    rd(sfrpe_pkg::MAKER_ID);
    u_sfrpe_host.close_frame();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### testbench/sfrpe_core_checker.sv
// sfrpe_core_checker: port assertions of the serial flash engine
// assumes binding to sfrpe_core; all checks on the system clock
`timescale 1ns/1ps
`default_nettype none
module sfrpe_core_checker (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  input  wire logic       so_o,
  input  wire logic       so_oe_n_o,
  input  wire logic       busy_o,
  input  wire logic       write_enable_latch_o,
  input  wire logic       sequential_program_mode_o,
  input  wire logic [1:0] protect_level_o
);
  logic [19:0] busy_len_r;
  logic [19:0] busy_len_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  always_comb busy_len_nxt = busy_o ? busy_len_r + 20'd1 : 20'd0;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      busy_len_r <= 20'd0;
    else
      busy_len_r <= busy_len_nxt;
  sequence busy_hold_s;
    busy_o [*8];
  endsequence
  AST_OE_OFF: assert property (cs_n_i && $past(cs_n_i) |-> so_oe_n_o)
    else $error("output enabled outside a frame");
  AST_SO_RELEASED: assert property (so_oe_n_o |-> !so_o)
    else $error("serial out not parked low");
  AST_OE_IN_FRAME: assert property ($fell(so_oe_n_o) |-> !cs_n_i)
    else $error("output enabled while deselected");
  AST_LAUNCH_ON_RISE: assert property ($rose(busy_o) |-> cs_n_i && $past(cs_n_i))
    else $error("self-timed cycle began inside a frame");
  AST_LATCH_GATE: assert property ($rose(busy_o) |->
    $past(write_enable_latch_o) || $past(write_enable_latch_o, 2))
    else $error("cycle began without write latch");
  AST_PROTECT_GATE: assert property ($rose(busy_o) |-> $past(protect_level_o) != 2'h3)
    else $error("cycle began on a fully protected array");
  AST_LEVEL_SEL: assert property (!$stable(protect_level_o) |-> cs_n_i && $past(cs_n_i))
    else $error("protect level changed inside a frame");
  AST_BUSY_HOLD: assert property ($rose(busy_o) |-> busy_hold_s)
    else $error("busy dropped early");
  AST_BUSY_LEN: assert property ($fell(busy_o) |-> busy_len_r >= 20'd140)
    else $error("busy shorter than byte program time");
endmodule
bind sfrpe_core sfrpe_core_checker u_sfrpe_core_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
  .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
  .sequential_program_mode_o(sequential_program_mode_o), .protect_level_o(protect_level_o));
`default_nettype wire

// ### testbench/sfrpe_host.sv
// sfrpe_host: spi host model, mode 0, drives select, clock and data in
// assumes a 125 ns serial period; the clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sfrpe_host (
  input  wire logic       so_i,
  output logic            sck_o,
  output logic            cs_n_o,
  output logic            si_o,
  output logic [7:0]      rx_o,
  output logic            rx_tgl_o
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    rx_o = 8'h00;
    rx_tgl_o = 1'b0;
  end
  task automatic open_frame();
    cs_n_o = 1'b0;
    #100;
  endtask
  // short counts leave a slot unfinished on purpose
  task automatic put(input logic [7:0] b, input int nbits = 8);
    for (int i = 7; i > 7 - nbits; i--)
    begin
      si_o = b[i];
      #62.5 sck_o = 1'b1;
      #62.5 sck_o = 1'b0;
    end
  endtask
  task automatic get();
    for (int i = 7; i >= 0; i--)
    begin
      si_o = ~si_o;
      #62.5 sck_o = 1'b1;
      rx_o[i] = so_i;
      #62.5 sck_o = 1'b0;
    end
    rx_tgl_o = ~rx_tgl_o;
  endtask
  // gap covers the 4 system clocks the engine needs
  task automatic close_frame();
    #62.5 cs_n_o = 1'b1;
    si_o = ~si_o;
    #500;
  endtask
endmodule
`default_nettype wire
